// *** ats_pkg.sv ***
/*
 Constants for the asynchronous timer update block: register offsets,
 field positions, reset values and prescaler layout.
 Assumes an AXI4-Lite slave with 32-bit data; registers are 8 bits wide.
*/
package ats_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_COUNT = 8'h00;
	localparam logic [7:0] OFS_COMPARE = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_ASYNC = 8'h0C;
	localparam logic [7:0] OFS_GTC = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	// Async status/control fields
	localparam int ASY_EXT_SEL = 4;
	localparam int ASY_ASYNC_SEL = 3;
	localparam int ASY_CNT_PEND = 2;
	localparam int ASY_CMP_PEND = 1;
	localparam int ASY_CTL_PEND = 0;
	// General timer control fields
	localparam int GTC_HOLD = 7;
	localparam int GTC_PSR = 1;
	// Counter control fields
	localparam int CTL_CLEAR_ON_MATCH = 3;
	localparam int CTL_SEL_MSB = 2;
	// Interrupt status fields
	localparam int IRQ_OVF = 0;
	localparam int IRQ_CMP = 1;
	// Reset values and widths
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] COUNT_TOP = 8'hFF;
	localparam int PRESCALE_W = 12;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** ats_sync2.sv ***
/*
 Two flip-flop synchroniser for one level from outside the aclk domain.
 Assumes the input is quasi-static relative to aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ats_sync2 (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Level in and out
	input wire logic d,
	output logic q
);
	logic meta;

	// First stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= 1'b0;
			q <= 1'b0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// *** ats_timer.sv ***
/*
 8-bit timer with asynchronous clock option and update-pending handshake.
 Registers on AXI4-Lite. Crystal and external clock pins are sampled on aclk,
 so they must toggle well below half the aclk rate.
*/
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
// How it works
// - Clock select: zero I/O clock, one crystal
// - Switching source may corrupt timer registers
// - Crystal runs only while external select zero
// - Async count write sets counter pending
// - Async compare write sets compare pending
// - Async control write sets control pending
// - Count read returns live timer value
// - Compare, control read return temporary copy
// - Prescaler clear bit resets, self-clears synchronously
// - Async clear bit stays until reset done
// - Hold mode keeps clear bit set
`timescale 1ns/10ps
`default_nettype none
module ats_timer (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Clock pins
	input wire logic crystal_osc_pin,
	input wire logic ext_clock_pin,
	output logic crystal_osc_enable,
	// Interrupt
	output logic irq
);
	import ats_pkg::*;

	logic aw_full, w_full;
	logic [7:0] aw_addr_q;
	logic [7:0] w_byte;
	logic w_lane;
	logic wr_go;
	logic [7:0] count_value, compare_value, counter_control;
	logic [7:0] compare_tmp, control_tmp, count_tmp;
	logic async_clock_select, external_clock_input_select;
	logic counter_update_pending, compare_update_pending, control_update_pending;
	logic prescaler_clear_request, sync_hold_mode;
	logic [1:0] irq_stat, irq_mask;
	logic xtal_s, ext_s, src_prev;
	logic tick, count_en, ovf_ev, cmp_ev;
	logic [PRESCALE_W-1:0] prescaler, pre_mask;
	logic wr_count, wr_compare, wr_control, wr_async, wr_gtc, wr_mask;
	logic rd_go, rd_stat;
	logic [7:0] next_rbyte;
	logic next_rok;

	// Pins pass two flops before anything reads them
	ats_sync2 u_sync_xtal (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(crystal_osc_pin),
		.q(xtal_s)
	);
	ats_sync2 u_sync_ext (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(ext_clock_pin),
		.q(ext_s)
	);

	// Write address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr_q <= REG_RESET;
			w_byte <= REG_RESET;
			w_lane <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			awready <= 1'b0;
			wready <= 1'b0;
		end else begin
			// Readies from flops: free slot next cycle and no response then
			awready <= !(aw_full || (awvalid && awready)) && !(wr_go || (bvalid && !bready));
			wready <= !(w_full || (wvalid && wready)) && !(wr_go || (bvalid && !bready));
			if (awvalid && awready) begin
				aw_full <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_full <= 1'b1;
				w_byte <= wdata[7:0];
				w_lane <= wstrb[0];
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (aw_addr_q <= OFS_IRQ_MASK && aw_addr_q[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// A write acts once both halves are held and no response waits
	assign wr_go = aw_full && w_full && !bvalid;
	assign wr_count = wr_go && w_lane && aw_addr_q == OFS_COUNT;
	assign wr_compare = wr_go && w_lane && aw_addr_q == OFS_COMPARE;
	assign wr_control = wr_go && w_lane && aw_addr_q == OFS_CONTROL;
	assign wr_async = wr_go && w_lane && aw_addr_q == OFS_ASYNC;
	assign wr_gtc = wr_go && w_lane && aw_addr_q == OFS_GTC;
	assign wr_mask = wr_go && w_lane && aw_addr_q == OFS_IRQ_MASK;

	// Timer input: every aclk when synchronous, pin rising edge when async
	assign tick = async_clock_select ? ((external_clock_input_select ? ext_s : xtal_s) && !src_prev) : 1'b1;

	// Clock source selects and pin history; the crystal stops under external select
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			async_clock_select <= 1'b0;
			external_clock_input_select <= 1'b0;
			crystal_osc_enable <= 1'b1;
			src_prev <= 1'b0;
		end else begin
			src_prev <= external_clock_input_select ? ext_s : xtal_s;
			if (wr_async) begin
				async_clock_select <= w_byte[ASY_ASYNC_SEL];
				external_clock_input_select <= w_byte[ASY_EXT_SEL];
			end
			crystal_osc_enable <= !external_clock_input_select;
		end
	end

	// Prescale divide 1,4,16,...: mask of low prescaler bits
	always_comb begin
		pre_mask = '0;
		case (counter_control[CTL_SEL_MSB:0])
			3'd2: pre_mask = 12'h003;
			3'd3: pre_mask = 12'h00F;
			3'd4: pre_mask = 12'h03F;
			3'd5: pre_mask = 12'h0FF;
			3'd6: pre_mask = 12'h3FF;
			3'd7: pre_mask = 12'hFFF;
			default: pre_mask = '0;
		endcase
	end
	assign count_en = tick && counter_control[CTL_SEL_MSB:0] != 3'd0 && (prescaler & pre_mask) == pre_mask;

	// Prescaler and its clear request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescaler <= '0;
			prescaler_clear_request <= 1'b0;
			sync_hold_mode <= 1'b0;
		end else begin
			if (prescaler_clear_request && tick) begin
				prescaler <= '0;
				if (!sync_hold_mode) begin
					prescaler_clear_request <= 1'b0;
				end
			end else if (tick) begin
				prescaler <= prescaler + 1'b1;
			end
			if (wr_gtc) begin
				sync_hold_mode <= w_byte[GTC_HOLD];
				if (w_byte[GTC_PSR]) begin
					prescaler_clear_request <= 1'b1;
				end
			end
		end
	end

	// Temporary copies and pending flags; a change of async clock select drops pending updates
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_tmp <= REG_RESET;
			compare_tmp <= REG_RESET;
			control_tmp <= REG_RESET;
			counter_update_pending <= 1'b0;
			compare_update_pending <= 1'b0;
			control_update_pending <= 1'b0;
		end else begin
			if (wr_async && w_byte[ASY_ASYNC_SEL] != async_clock_select) begin
				counter_update_pending <= 1'b0;
				compare_update_pending <= 1'b0;
				control_update_pending <= 1'b0;
			end else if (!async_clock_select) begin
				counter_update_pending <= 1'b0;
				compare_update_pending <= 1'b0;
				control_update_pending <= 1'b0;
			end else begin
				if (wr_count) begin
					counter_update_pending <= 1'b1;
				end else if (tick) begin
					counter_update_pending <= 1'b0;
				end
				if (wr_compare) begin
					compare_update_pending <= 1'b1;
				end else if (tick) begin
					compare_update_pending <= 1'b0;
				end
				if (wr_control) begin
					control_update_pending <= 1'b1;
				end else if (tick) begin
					control_update_pending <= 1'b0;
				end
			end
			// A write while pending simply overwrites the copy
			if (wr_count) begin
				count_tmp <= w_byte;
			end
			if (wr_compare) begin
				compare_tmp <= w_byte;
			end
			if (wr_control) begin
				control_tmp <= w_byte;
			end
		end
	end

	// Live timer registers
	assign cmp_ev = count_en && count_value == compare_value;
	assign ovf_ev = count_en && count_value == COUNT_TOP;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_value <= REG_RESET;
			compare_value <= REG_RESET;
			counter_control <= REG_RESET;
		end else begin
			if (!async_clock_select) begin
				if (wr_compare) begin
					compare_value <= w_byte;
				end
				if (wr_control) begin
					counter_control <= w_byte;
				end
			end else if (tick) begin
				if (compare_update_pending) begin
					compare_value <= compare_tmp;
				end
				if (control_update_pending) begin
					counter_control <= control_tmp;
				end
			end
			if (!async_clock_select && wr_count) begin
				count_value <= w_byte;
			end else if (async_clock_select && tick && counter_update_pending) begin
				count_value <= count_tmp;
			end else if (cmp_ev && counter_control[CTL_CLEAR_ON_MATCH]) begin
				count_value <= REG_RESET;
			end else if (count_en) begin
				count_value <= count_value + 1'b1;
			end
		end
	end

	// Read mux
	always_comb begin
		next_rbyte = REG_RESET;
		next_rok = 1'b1;
		case (araddr)
			OFS_COUNT: next_rbyte = count_value;
			OFS_COMPARE: next_rbyte = compare_tmp;
			OFS_CONTROL: next_rbyte = control_tmp;
			OFS_ASYNC: next_rbyte = {3'b000, external_clock_input_select, async_clock_select,
				counter_update_pending, compare_update_pending, control_update_pending};
			OFS_GTC: next_rbyte = {sync_hold_mode, 5'b00000, prescaler_clear_request, 1'b0};
			OFS_IRQ_STAT: next_rbyte = {6'b000000, irq_stat};
			OFS_IRQ_MASK: next_rbyte = {6'b000000, irq_mask};
			default: next_rok = 1'b0;
		endcase
	end
	assign rd_go = arvalid && arready;
	assign rd_stat = rd_go && araddr == OFS_IRQ_STAT;

	// Read channel: one read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end else begin
			if (rd_go) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= {24'h000000, next_rbyte};
				rresp <= next_rok ? RESP_OKAY : RESP_SLVERR;
			end else if (!rvalid || rready) begin
				rvalid <= 1'b0; // Also raises arready after reset
				arready <= 1'b1;
			end
		end
	end

	// Sticky events, cleared by reading; a new event beats the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= 2'b00;
			irq_mask <= 2'b00;
			irq <= 1'b0;
		end else begin
			irq_stat[IRQ_OVF] <= ovf_ev || (irq_stat[IRQ_OVF] && !rd_stat);
			irq_stat[IRQ_CMP] <= cmp_ev || (irq_stat[IRQ_CMP] && !rd_stat);
			if (wr_mask) begin
				irq_mask <= w_byte[1:0];
			end
			irq <= |(irq_stat & irq_mask);
		end
	end

	AST_SYNC_NO_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
		!async_clock_select && $past(!async_clock_select) |-> !counter_update_pending && !compare_update_pending)
		else $error("pending flag set in synchronous mode");
	AST_CNT_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
		async_clock_select && wr_count && !wr_async |=> counter_update_pending)
		else $error("count write did not set pending");
	AST_CMP_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
		async_clock_select && wr_compare && !wr_async |=> compare_update_pending)
		else $error("compare write did not set pending");
	AST_CTL_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
		async_clock_select && wr_control && !wr_async |=> control_update_pending)
		else $error("control write did not set pending");
	AST_CNT_XFER: assert property (@(posedge aclk) disable iff (!aresetn)
		async_clock_select && counter_update_pending && tick && !wr_go |=>
		!counter_update_pending && count_value == $past(count_tmp))
		else $error("count transfer missing");
	AST_PSR_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
		prescaler_clear_request && !async_clock_select && !sync_hold_mode && !wr_gtc |=>
		!prescaler_clear_request && prescaler == 12'h000)
		else $error("prescaler clear did not self-clear");
	AST_PSR_ASYNC: assert property (@(posedge aclk) disable iff (!aresetn)
		prescaler_clear_request && !tick |=> prescaler_clear_request)
		else $error("clear request dropped before reset");
	AST_PSR_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		prescaler_clear_request && sync_hold_mode |=> prescaler_clear_request)
		else $error("clear request dropped in hold mode");
	AST_OSC: assert property (@(posedge aclk) disable iff (!aresetn)
		external_clock_input_select ##1 external_clock_input_select |-> !crystal_osc_enable)
		else $error("crystal running under external clock");
	AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		|(irq_stat & irq_mask) |=> irq)
		else $error("interrupt not raised");
endmodule
`default_nettype wire

// *** ats_clk_src.sv ***
/*
 Far-side model: timer crystal and external clock source.
 Assumes the bench clock aclk; pins move on its falling edge, far from sampling.
*/
`timescale 1ns/10ps
`default_nettype none
module ats_clk_src #(parameter int HALF = 8) (
	// Bench clock
	input wire logic aclk,
	// Oscillator enable from the timer
	input wire logic crystal_osc_enable,
	// Clock pins
	output logic crystal_osc_pin,
	output logic ext_clock_pin
);
	// Crystal swings only while enabled, holds its level when stopped
	initial begin
		crystal_osc_pin = 1'h0;
		forever begin
			repeat (HALF) @(negedge aclk);
			if (crystal_osc_enable) crystal_osc_pin = ~crystal_osc_pin;
		end
	end
	// External source idles low between bursts
	initial ext_clock_pin = 1'h0;
	// Exact edge count, slow so the synchroniser never misses one
	task automatic burst(input int n);
		repeat (n) begin
			repeat (HALF) @(negedge aclk);
			ext_clock_pin = 1'h1;
			repeat (HALF) @(negedge aclk);
			ext_clock_pin = 1'h0;
		end
	endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
/*
 Self-checking bench for the async timer block.
 Assumes ats_pkg, ats_timer and the clock source model ats_clk_src.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import ats_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, xo, xe, xen, irq;
	logic [7:0] awaddr, araddr, v, c0, c1;
	logic [31:0] wdata, rdata, d, lf;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	int err_count, checked;
	ats_timer DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .crystal_osc_pin(xo), .ext_clock_pin(xe),
		.crystal_osc_enable(xen), .irq(irq));
	ats_clk_src SRC (.aclk(aclk), .crystal_osc_enable(xen), .crystal_osc_pin(xo), .ext_clock_pin(xe));
	// 50 MHz clock
	initial begin
		aclk = 1'h0;
		forever #10 aclk = ~aclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [31:0] wd(input logic [7:0] b);
		return {24'h000000, b};
	endfunction
	// One when an 8-bit distance lies in a window
	function automatic logic [31:0] inr(input logic [7:0] x, input logic [7:0] lo, input logic [7:0] hi);
		return {31'h0, (x >= lo) && (x <= hi)};
	endfunction
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", n, exp, seen);
			err_count++;
		end
	endtask
	// Each channel is released after the edge that took it
	task automatic wr(input logic [7:0] a, input logic [7:0] b, input logic [3:0] s, output logic [1:0] rs);
		logic ca, cw, cb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= wd(b);
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		cb = 1'h0;
		while (!cb) begin
			@(negedge aclk);
			ca = awvalid && awready;
			cw = wvalid && wready;
			cb = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ca) awvalid <= 1'h0;
			if (cw) wvalid <= 1'h0;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rs);
		logic ca, cr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		cr = 1'h0;
		while (!cr) begin
			@(negedge aclk);
			ca = arvalid && arready;
			cr = rvalid;
			q = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ca) arvalid <= 1'h0;
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] b);
		logic [1:0] rs;
		wr(a, b, 4'hF, rs);
		chk("write resp", {30'h0, rs}, {30'h0, RESP_OKAY});
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic [1:0] rs;
		rd(a, q, rs);
		chk("register read", q, e);
		chk("read resp", {30'h0, rs}, {30'h0, RESP_OKAY});
	endtask
	task automatic summarize();
		if (err_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog, far beyond the several hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		summarize();
	end
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, arvalid} = 4'h0;
		{bready, rready} = 2'h3;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		{err_count, checked} = 0;
		lf = 32'hEB2BF674;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		// Reset values and unmapped places
		rc(OFS_COMPARE, 32'h0);
		rc(OFS_CONTROL, 32'h0);
		rc(OFS_ASYNC, 32'h0);
		rc(OFS_GTC, 32'h0);
		rc(OFS_IRQ_MASK, 32'h0);
		rd(8'h1C, d, r);
		chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'h1C, 8'h55, 4'hF, r);
		chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
		// Sync writes act at once and leave the flags clear
		repeat (4) begin
			lf = lfsr(lf);
			v = lf[7:0];
			w(OFS_COMPARE, v);
			rc(OFS_COMPARE, wd(v));
		end
		wr(OFS_COMPARE, ~v, 4'h0, r);
		rc(OFS_COMPARE, wd(v));
		rc(OFS_ASYNC, 32'h0);
		// Prescaler clear: self-clearing, held while hold mode is on
		w(OFS_GTC, 8'h02);
		rc(OFS_GTC, 32'h0);
		w(OFS_GTC, 8'h82);
		rc(OFS_GTC, 32'h82);
		w(OFS_GTC, 8'h00);
		rc(OFS_GTC, 32'h0);
		// Overflow event: masked, then unmasked, then read-cleared
		w(OFS_COMPARE, 8'h00);
		w(OFS_COUNT, 8'hF0);
		w(OFS_CONTROL, 8'h01);
		repeat (40) @(posedge aclk);
		w(OFS_CONTROL, 8'h00);
		@(negedge aclk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		w(OFS_IRQ_MASK, 8'h01);
		repeat (2) @(negedge aclk);
		chk("irq raised", {31'h0, irq}, 32'h1);
		rd(OFS_IRQ_STAT, d, r);
		chk("overflow flag", d & 32'h1, 32'h1);
		chk("compare flag", d & 32'h2, 32'h2);
		repeat (2) @(negedge aclk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		rc(OFS_IRQ_STAT, 32'h0);
		w(OFS_IRQ_MASK, 8'h00);
		w(OFS_COUNT, 8'h5A);
		// External select first, so the crystal never sees async mode
		w(OFS_ASYNC, 8'h10);
		@(negedge aclk);
		chk("osc enable", {31'h0, xen}, 32'h0);
		w(OFS_ASYNC, 8'h18);
		w(OFS_COUNT, 8'h3C);
		w(OFS_COMPARE, 8'hC3);
		w(OFS_CONTROL, 8'h08);
		rc(OFS_ASYNC, 32'h1F);
		rc(OFS_COUNT, 32'h5A);
		rc(OFS_COMPARE, 32'hC3);
		rc(OFS_CONTROL, 32'h08);
		w(OFS_GTC, 8'h02);
		rc(OFS_GTC, 32'h02);
		SRC.burst(2);
		rc(OFS_ASYNC, 32'h18);
		rc(OFS_COUNT, 32'h3C);
		rc(OFS_GTC, 32'h0);
		// Count on external edges, exactly one step each
		w(OFS_CONTROL, 8'h01);
		SRC.burst(1);
		rd(OFS_COUNT, d, r);
		c0 = d[7:0];
		SRC.burst(5);
		rd(OFS_COUNT, d, r);
		c1 = d[7:0];
		chk("edge count", wd(c1 - c0), 32'h5);
		// Crystal: about one step per sixteen bus clocks
		w(OFS_ASYNC, 8'h08);
		repeat (3) @(negedge aclk);
		chk("osc enable", {31'h0, xen}, 32'h1);
		rd(OFS_COUNT, d, r);
		c0 = d[7:0];
		repeat (160) @(posedge aclk);
		rd(OFS_COUNT, d, r);
		c1 = d[7:0];
		chk("crystal rate", inr(c1 - c0, 8'h08, 8'h0C), 32'h1);
		// Back to the bus clock; contents not trusted after a switch
		w(OFS_ASYNC, 8'h00);
		w(OFS_CONTROL, 8'h01);
		rd(OFS_COUNT, d, r);
		c0 = d[7:0];
		repeat (100) @(posedge aclk);
		rd(OFS_COUNT, d, r);
		c1 = d[7:0];
		chk("sync rate", inr(c1 - c0, 8'h64, 8'h70), 32'h1);
		summarize();
	end
endmodule
`default_nettype wire
